// *** core/lmu_i2c_slave.sv ***
// two-wire serial slave port of the lighting unit, register write stream out
//
// Contract
// - data changes only while clock is low
// - falling data, clock high: start condition
// - rising data, clock high: stop condition
// - bus busy from start until stop
// - repeated start acts as fresh start
// - eight bits per byte, msb first
// - receiver pulls data low on ninth pulse
// - transmitter releases data during acknowledge pulse
// - once addressed, acknowledge every received byte
// - first byte: seven address bits, direction bit
// - answer only address hex 59
// - write: index byte, then data byte
// - write takes effect at final acknowledge rise
`timescale 1ns/100ps
module lmu_i2c_slave
  import lmu_pkg::*;
#(
  parameter int FIFO_DEPTH = LMU_FIFO_DEPTH
) (
  // system clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_rst,
  // serial link: clock from the master, data as three signals
  input  wire logic              i_scl_clk,
  input  wire logic              i_sda,
  output logic                   o_sda,
  output logic                   o_sda_oe,
  // session status
  output logic                   o_busy,
  // register read: index out, contents back
  output logic      [LMU_IW-1:0] o_rd_index,
  input  wire logic [LMU_DW-1:0] i_rd_data,
  // register write stream
  output logic                   o_wr_valid,
  input  wire logic              i_wr_ready,
  output logic      [LMU_IW-1:0] o_wr_index,
  output logic      [LMU_DW-1:0] o_wr_data,
  output logic                   o_wr_drop
);

  if (FIFO_DEPTH < 2) begin : g_chk
    $error("lmu_i2c_slave needs a write buffer of two or more words");
  end

  // ----------------------------------------------------------------
  // link domain
  // ----------------------------------------------------------------
  typedef struct packed {
    logic tog;
    logic dbit;
  } lmu_link_t;

  lmu_link_t lk_q;
  lmu_link_t lk_d;

  // each clock rise flips the toggle and keeps the sampled data bit;
  // both then stand a whole clock period, far longer than the crossing
  always_comb begin
    lk_d      = lk_q;
    lk_d.tog  = ~lk_q.tog;
    lk_d.dbit = i_sda;
  end

  // the link clock may stand still, so reset cannot wait for its edge
  always_ff @(posedge i_scl_clk or posedge i_rst) begin
    if (i_rst) begin
      lk_q <= '0;
    end else begin
      lk_q <= lk_d;
    end
  end

  // ----------------------------------------------------------------
  // crossing into the system domain
  // ----------------------------------------------------------------
  logic [3:0] sy;
  logic       scl_s;
  logic       sda_s;
  logic       tog_s;
  logic       bit_s;

  lmu_sync #(
    .W (4)
  ) u_sync (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .i_d   ({i_scl_clk, i_sda, lk_q.tog, lk_q.dbit}),
    .o_q   (sy)
  );

  assign {scl_s, sda_s, tog_s, bit_s} = sy;

  // ----------------------------------------------------------------
  // write buffer
  // ----------------------------------------------------------------
  lmu_strm_if #(.W(LMU_IW + LMU_DW)) push_if ();
  lmu_strm_if #(.W(LMU_IW + LMU_DW)) pop_if ();

  lmu_fifo #(
    .W     (LMU_IW + LMU_DW),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .s_in  (push_if.snk),
    .s_out (pop_if.src)
  );

  // ----------------------------------------------------------------
  // core state and bus conditions
  // ----------------------------------------------------------------
  lmu_core_t q;
  lmu_core_t d;
  logic      start;
  logic      stop;
  logic      fall;
  logic      apply;
  logic      drive_low;
  logic      commit;
  logic [7:0] byte_in;

  // conditions seen on the synchronised levels
  assign start   = scl_s & q.scl_p & q.sda_p & ~sda_s;
  assign stop    = scl_s & q.scl_p & ~q.sda_p & sda_s;
  assign fall    = q.scl_p & ~scl_s;
  assign apply   = (q.hold == 5'h1);
  assign byte_in = {q.sh[6:0], bit_s};
  assign commit  = q.ev & (q.st == ST_ACK) & (q.role == RL_DATA);

  // level wanted on the data line for the bit after the next fall
  assign drive_low = (q.st == ST_ACK)
                   | ((q.st == ST_TX) & ~q.txb[7]);

  // ----------------------------------------------------------------
  // protocol engine
  // ----------------------------------------------------------------
  always_comb begin
    d       = q;
    d.scl_p = scl_s;
    d.sda_p = sda_s;
    d.tog_p = tog_s;
    d.ev    = tog_s ^ q.tog_p;  // one cycle late so the bit has settled
    d.drop  = 1'b0;

    // buffered word leaves; a new commit below wins over this
    if (push_if.ready) begin
      d.pend = 1'b0;
    end

    // data changes only after the hold time past the clock fall
    if (fall) begin
      d.hold = LMU_HOLD_LD;
    end else if (q.hold != 5'h0) begin
      d.hold = q.hold - 5'h1;
    end
    if (apply) begin
      d.oe = drive_low;
    end

    // one clock rise has been seen
    if (q.ev) begin
      unique case (q.st)
        ST_RX: begin
          d.sh  = byte_in;
          d.cnt = q.cnt + 3'h1;
          if (q.cnt == LMU_BIT_LAST) begin
            unique case (q.role)
              RL_ADDR: begin
                if (byte_in[7:1] == LMU_DEV_ADDR) begin
                  d.rw = byte_in[0];
                  d.st = ST_ACK;
                end else begin
                  d.st = ST_IGN;
                end
              end
              RL_INDEX: begin
                d.idx = byte_in;
                d.st  = ST_ACK;
              end
              RL_DATA: begin
                d.dat = byte_in;
                d.st  = ST_ACK;
              end
              default: begin
                d.st = ST_IGN;
              end
            endcase
          end
        end
        ST_ACK: begin
          d.cnt = 3'h0;
          unique case (q.role)
            RL_ADDR: begin
              if (q.rw) begin
                d.st  = ST_TX;
                d.txb = i_rd_data;
              end else begin
                d.st   = ST_RX;
                d.role = RL_INDEX;
              end
            end
            RL_INDEX: begin
              d.st   = ST_RX;
              d.role = RL_DATA;
            end
            RL_DATA: begin
              // full buffer: a still pending word is overwritten
              d.drop  = q.pend & ~push_if.ready;
              d.pend  = 1'b1;
              d.wword = {q.idx, q.dat};
              d.st    = ST_RX;
            end
            default: begin
              d.st = ST_IGN;
            end
          endcase
        end
        ST_TX: begin
          d.txb = {q.txb[6:0], 1'b0};
          d.cnt = q.cnt + 3'h1;
          if (q.cnt == LMU_BIT_LAST) begin
            d.st = ST_MACK;
          end
        end
        ST_MACK: begin
          if (!bit_s) begin
            d.st  = ST_TX;
            d.txb = i_rd_data;
          end else begin
            d.st = ST_IGN;
          end
        end
        ST_IDLE, ST_IGN: begin
          d.st = q.st;
        end
        default: begin
          d.st = ST_IGN;  // unused codes park until the next start or stop
        end
      endcase
    end

    // a start, first or repeated, restarts address reception
    if (start) begin
      d.st   = ST_RX;
      d.role = RL_ADDR;
      d.cnt  = 3'h0;
      d.busy = 1'b1;
      d.oe   = 1'b0;
      d.hold = 5'h0;
    end
    if (stop) begin
      d.st   = ST_IDLE;
      d.busy = 1'b0;
      d.oe   = 1'b0;
      d.hold = 5'h0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      q <= LMU_CORE_RST;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // open drain: only a low is ever driven; start and stop never are
  assign o_sda          = 1'b0;
  assign o_sda_oe       = q.oe;
  assign o_busy         = q.busy;
  assign o_rd_index     = q.idx;
  assign o_wr_drop      = q.drop;
  assign push_if.valid  = q.pend;
  assign push_if.data   = q.wword;
  assign o_wr_valid     = pop_if.valid;
  assign {o_wr_index, o_wr_data} = pop_if.data;
  assign pop_if.ready   = i_wr_ready;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  a_start_opens_session: assert property (
    start |=> q.busy && q.st == ST_RX && q.cnt == 3'h0
  ) else $error("start did not open address reception");

  a_stop_frees_bus: assert property (
    stop |=> !q.busy && q.st == ST_IDLE && !o_sda_oe
  ) else $error("stop did not free the bus");

  a_busy_until_stop: assert property (
    q.busy && !stop |=> q.busy
  ) else $error("bus freed without stop");

  a_restart_mid_sess: assert property (
    start && q.busy |=> q.st == ST_RX && q.role == RL_ADDR && q.busy
  ) else $error("repeated start not taken as start");

  a_data_stable_high: assert property (
    $changed(o_sda_oe) && !$past(start) && !$past(stop) |-> $past(!scl_s, 2)
  ) else $error("data line moved while clock high");

  a_ack_driven: assert property (
    apply && q.st == ST_ACK && !start && !stop |=> o_sda_oe
  ) else $error("acknowledge not driven low");

  a_mack_released: assert property (
    apply && q.st == ST_MACK |=> !o_sda_oe
  ) else $error("data not released for master acknowledge");

  a_foreign_addr: assert property (
    q.ev && q.st == ST_RX && q.role == RL_ADDR && q.cnt == LMU_BIT_LAST
      && byte_in[7:1] != LMU_DEV_ADDR && !start && !stop |=> q.st == ST_IGN
  ) else $error("foreign address was not ignored");

  a_ignore_silent: assert property (
    q.st == ST_IGN && !start |=> q.st == ST_IGN || q.st == ST_IDLE
  ) else $error("ignored session left without start");

  a_commit_word: assert property (
    commit && !start && !stop |=> q.pend && q.wword == {$past(q.idx), $past(q.dat)}
  ) else $error("write not committed at final acknowledge");

  a_ack_after_byte: assert property (
    q.ev && q.st == ST_RX && q.role != RL_ADDR && q.cnt == LMU_BIT_LAST
      && !start && !stop |=> q.st == ST_ACK
  ) else $error("received byte not acknowledged");

  c_write_commit: cover property (commit);
  c_read_byte:    cover property (q.ev && q.st == ST_MACK);
  c_foreign_addr: cover property (q.st == ST_RX ##1 q.st == ST_IGN);
  c_drop_word:    cover property (o_wr_drop);

endmodule : lmu_i2c_slave

// *** common/lmu_pkg.sv ***
// constants, state encodings and state records of the lighting unit serial slave
package lmu_pkg;

  // ----------------------------------------------------------------
  // bus addressing and framing
  // ----------------------------------------------------------------
  localparam logic [6:0] LMU_DEV_ADDR = 7'h59;  // fixed target address
  localparam logic [2:0] LMU_BIT_LAST = 3'h7;   // last bit of an eight bit byte
  localparam int         LMU_IW       = 8;      // register index width
  localparam int         LMU_DW       = 8;      // register data width
  localparam int         LMU_FIFO_DEPTH = 32;   // write words buffered

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int         LMU_CLK_MHZ  = 50;
  localparam int         LMU_HOLD_NS  = 300;    // least data hold after clock fall
  localparam int         LMU_HOLD_CYC = (LMU_HOLD_NS * LMU_CLK_MHZ + 999) / 1000;
  localparam logic [4:0] LMU_HOLD_LD  = 5'(LMU_HOLD_CYC);

  // ----------------------------------------------------------------
  // state encodings
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_RX   = 3'h1,
    ST_ACK  = 3'h3,
    ST_TX   = 3'h2,
    ST_MACK = 3'h6,
    ST_IGN  = 3'h7
  } lmu_st_t;

  typedef enum logic [1:0] {
    RL_ADDR  = 2'h0,
    RL_INDEX = 2'h1,
    RL_DATA  = 2'h3
  } lmu_role_t;

  // ----------------------------------------------------------------
  // core state record
  // ----------------------------------------------------------------
  typedef struct packed {
    lmu_st_t           st;
    lmu_role_t         role;
    logic [2:0]        cnt;
    logic [7:0]        sh;
    logic              rw;
    logic [LMU_IW-1:0] idx;
    logic [LMU_DW-1:0] dat;
    logic [7:0]        txb;
    logic              busy;
    logic              oe;
    logic [4:0]        hold;
    logic              scl_p;
    logic              sda_p;
    logic              tog_p;
    logic              ev;
    logic              pend;
    logic [15:0]       wword;
    logic              drop;
  } lmu_core_t;

  localparam lmu_core_t LMU_CORE_RST = '0;

endpackage : lmu_pkg

// *** common/lmu_strm_if.sv ***
// valid/ready word stream between the slave core and its write buffer
`timescale 1ns/100ps
interface lmu_strm_if #(
  parameter int W = 16
) ();
  logic         valid;
  logic         ready;
  logic [W-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : lmu_strm_if

// *** core/lmu_sync.sv ***
// two flip-flop level synchroniser for a group of asynchronous bits
`timescale 1ns/100ps
module lmu_sync #(
  parameter int W = 4
) (
  // clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  // asynchronous levels in, synchronised levels out
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } lmu_sync_t;

  lmu_sync_t q;
  lmu_sync_t d;

  // first stage feeds only the second
  always_comb begin
    d    = q;
    d.s1 = i_d;
    d.s2 = q.s1;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_q = q.s2;
endmodule : lmu_sync

// *** core/lmu_fifo.sv ***
// synchronous word buffer with valid/ready on both sides
`timescale 1ns/100ps
module lmu_fifo #(
  parameter int W     = 16,
  parameter int DEPTH = 32
) (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst,
  // fill side and drain side
  lmu_strm_if.snk   s_in,
  lmu_strm_if.src   s_out
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
    $error("lmu_fifo depth must be a power of two");
  end

  typedef struct packed {
    logic [AW:0]   cnt;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
  } lmu_fifo_st_t;

  lmu_fifo_st_t q;
  lmu_fifo_st_t d;
  logic [W-1:0] mem [DEPTH];
  logic         wr;
  logic         rd;

  // full stalls the source, empty hides the output
  assign s_in.ready  = (q.cnt != (AW+1)'(DEPTH));
  assign s_out.valid = (q.cnt != '0);
  assign s_out.data  = mem[q.rp];
  assign wr          = s_in.valid & s_in.ready;
  assign rd          = s_out.valid & s_out.ready;

  always_comb begin
    d = q;
    if (wr) begin
      d.wp = q.wp + 1'b1;
    end
    if (rd) begin
      d.rp = q.rp + 1'b1;
    end
    d.cnt = q.cnt + (AW+1)'(wr) - (AW+1)'(rd);
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // storage needs no reset
  always_ff @(posedge i_clk) begin
    if (wr) begin
      mem[q.wp] <= s_in.data;
    end
  end
endmodule : lmu_fifo

// *** testbench/lmu_mst_model.sv ***
// behavioural two-wire bus master that drives the serial clock and data line
`timescale 1ns/100ps
module lmu_mst_model (
  // device drive on the data line: level and enable
  input  wire logic i_sda_drv,
  input  wire logic i_sda_oe,
  // resolved bus lines
  output logic      o_scl,
  output logic      o_sda
);
  // ----------------------------------------------------------------
  // timebase and bus lines
  // ----------------------------------------------------------------
  logic tick     = 1'b0;
  logic pull_low = 1'b0;

  // 80 ns timebase, offset so it never lines up with the system clock
  initial begin
    #13;
    forever #40 tick = ~tick;
  end

  // open drain with pull-up: released line reads high, a driven high pulls nothing
  assign o_sda = ~(pull_low | (i_sda_oe & ~i_sda_drv));
  // clock rests high between frames
  initial o_scl = 1'b1;

  task automatic wait_t(input int n);
    repeat (n) @(posedge tick);
  endtask : wait_t

  // one pulse: low 1.6 us with data set mid-low, high 800 ns
  task automatic bit_io(input logic b, output logic s);
    o_scl = 1'b0;
    wait_t(10);
    pull_low = ~b;
    wait_t(10);
    o_scl = 1'b1;
    wait_t(5);
    s = o_sda;
    wait_t(5);
  endtask : bit_io

  // from idle: data falls while clock high
  task automatic start();
    pull_low = 1'b1;
    wait_t(8);
  endtask : start

  // from mid-frame: set a, raise clock, move data to b
  task automatic cond(input logic a, input logic b);
    o_scl = 1'b0;
    wait_t(10);
    pull_low = a;
    wait_t(10);
    o_scl = 1'b1;
    wait_t(8);
    pull_low = b;
    wait_t(16);
  endtask : cond

  task automatic stop();
    cond(1'b1, 1'b0);
  endtask : stop

  task automatic rstart();
    cond(1'b0, 1'b1);
  endtask : rstart

  // byte out msb first, then release for the device answer
  task automatic send(input logic [7:0] v, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(v[i], s);
    bit_io(1'b1, ack);
  endtask : send

  // byte in, then our own answer on the ninth pulse
  task automatic recv(input logic nack, output logic [7:0] v);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      v[i] = s;
    end
    bit_io(nack, s);
  endtask : recv
endmodule : lmu_mst_model

// *** testbench/lighting_unit_i2c_slave_tb.sv ***
// self-checking bench of the serial slave port against a bus master model
`timescale 1ns/100ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("mismatch at %0t: got %h want %h", $time, g, e); end end
module lighting_unit_i2c_slave_tb;
  import lmu_pkg::*;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  localparam int LIMIT = 80000;
  logic        i_clk = 1'b0;
  logic        i_rst = 1'b1;
  logic        scl, sda, sda_drv, oe, busy, wr_valid, wr_drop;
  logic        i_wr_ready = 1'b0;
  logic [7:0]  rd_index, wr_index, wr_data, last_idx;
  logic [15:0] exp_q[$];
  logic        ready_en = 1'b1;
  int          mismatches = 0;
  int          n_checks = 0;
  int          drops = 0;
  int          cycles = 0;

  always #10 i_clk = ~i_clk;

  // register contents seen by reads, a fixed map of the index
  function automatic logic [7:0] exp_rd(input logic [7:0] idx);
    return idx ^ 8'h5a;
  endfunction : exp_rd

  lmu_i2c_slave #(.FIFO_DEPTH(4)) u_lmu_i2c_slave (
    .i_clk(i_clk), .i_rst(i_rst), .i_scl_clk(scl), .i_sda(sda), .o_sda(sda_drv), .o_sda_oe(oe),
    .o_busy(busy), .o_rd_index(rd_index), .i_rd_data(exp_rd(rd_index)),
    .o_wr_valid(wr_valid), .i_wr_ready(i_wr_ready), .o_wr_index(wr_index),
    .o_wr_data(wr_data), .o_wr_drop(wr_drop));

  lmu_mst_model u_lmu_mst_model (.i_sda_drv(sda_drv), .i_sda_oe(oe), .o_scl(scl),
                                 .o_sda(sda));

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : wrap_up

  // ----------------------------------------------------------------
  // stream consumer, scoreboard, timeout
  // ----------------------------------------------------------------
  always @(posedge i_clk) begin
    i_wr_ready <= #1 ready_en & 1'($urandom_range(0, 1));
    if (!i_rst && wr_valid === 1'b1 && i_wr_ready === 1'b1) begin
      `CHK({wr_index, wr_data}, exp_q[0])
      void'(exp_q.pop_front());
    end
    if (wr_drop === 1'b1) drops++;
    cycles++;
    if (cycles == LIMIT) begin
      mismatches++;
      wrap_up();
    end
  end

  // device pull may only move while the clock is low
  always @(oe) if (!i_rst && scl === 1'b1) begin
    mismatches++;
    $display("mismatch at %0t: data moved with clock high", $time);
  end

  // write session; skip marks a word expected to be overwritten
  task automatic wr_sess(input logic [7:0] adr, input logic [7:0] idx, input int n,
                         input int skip);
    logic       ack, own;
    logic [7:0] d;
    own = (adr[7:1] == LMU_DEV_ADDR) && !adr[0];
    u_lmu_mst_model.start();
    u_lmu_mst_model.send(adr, ack);
    `CHK(ack, ~own)
    `CHK(busy, 1'b1)
    u_lmu_mst_model.send(idx, ack);
    `CHK(ack, ~own)
    for (int j = 0; j < n; j++) begin
      d = 8'($urandom);
      // expect the word before it can reach the stream, the consumer may be quick
      if (own && j != skip) exp_q.push_back({idx, d});
      u_lmu_mst_model.send(d, ack);
      `CHK(ack, ~own)
      if (own && !ready_en && j == 0) `CHK(wr_valid, 1'b1)
    end
    if (own) last_idx = idx;
    u_lmu_mst_model.stop();
    `CHK(busy, 1'b0)
    `CHK(rd_index, last_idx)
  endtask : wr_sess

  // read session, optionally after a foreign address and a repeated start
  task automatic rd_sess(input logic [7:0] idx, input logic pre);
    logic       ack;
    logic [7:0] v;
    u_lmu_mst_model.start();
    if (pre) begin
      u_lmu_mst_model.send({7'h58, 1'b0}, ack);
      `CHK(ack, 1'b1)
      u_lmu_mst_model.rstart();
    end
    u_lmu_mst_model.send({LMU_DEV_ADDR, 1'b0}, ack);
    `CHK(ack, 1'b0)
    u_lmu_mst_model.send(idx, ack);
    u_lmu_mst_model.rstart();
    u_lmu_mst_model.send({LMU_DEV_ADDR, 1'b1}, ack);
    `CHK(ack, 1'b0)
    if (pre) begin
      u_lmu_mst_model.recv(1'b0, v);
      `CHK(v, exp_rd(idx))
    end
    u_lmu_mst_model.recv(1'b1, v);
    `CHK(v, exp_rd(idx))
    u_lmu_mst_model.stop();
    `CHK(busy, 1'b0)
    last_idx = idx;
  endtask : rd_sess

  task automatic drain();
    for (int t = 0; t < 400 && exp_q.size() != 0; t++) @(posedge i_clk);
    repeat (3) @(posedge i_clk);
    `CHK(exp_q.size(), 0)
    `CHK(wr_valid, 1'b0)
  endtask : drain

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [6:0] a;
    last_idx = 8'h00;
    void'($urandom(32'h111cb8ec));
    repeat (6) @(posedge i_clk);
    #1 i_rst = 1'b0;
    repeat (10) @(posedge i_clk);
    for (int k = 0; k < 4; k++)
      wr_sess({LMU_DEV_ADDR, 1'b0}, k == 0 ? 8'h00 : k == 1 ? 8'hff : 8'($urandom), k % 3 + 1, -1);
    drain();
    $display("test writes done");
    for (int k = 0; k < 2; k++) begin
      do a = 7'($urandom); while (a == LMU_DEV_ADDR);
      wr_sess({k == 0 ? 7'h5a : a, 1'($urandom)}, 8'($urandom), 1, -1);
    end
    drain();
    $display("test foreign address done");
    rd_sess(8'($urandom), 1'b0);
    rd_sess(8'h00, 1'b1);
    $display("test reads done");
    ready_en = 1'b0;
    repeat (3) @(posedge i_clk);
    wr_sess({LMU_DEV_ADDR, 1'b0}, 8'($urandom), 6, 4);
    `CHK(drops, 1)
    ready_en = 1'b1;
    drain();
    $display("test buffer full done");
    wrap_up();
  end
endmodule : lighting_unit_i2c_slave_tb
